// File: tb/fepe_flash_model.sv
/*
  behavioural model of the byte-wide nor flash: command decode, embedded
  program and erase with status bits and a busy pin.
  assumes pins are sampled on clk; hang freezes the embedded algorithm.
*/
module fepe_flash_model
  import fepe_pkg::*;
#(
  parameter int unsigned PROG_CYC  = 20,
  parameter int unsigned ERASE_CYC = 60
)
(
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_out,
  input  wire logic              ce_n,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic              hang,
  output logic      [DATA_W-1:0] dq_in,
  output logic                   rdy_busy
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] wa, pa;
  logic [DATA_W-1:0] wd, pd, last = 8'h00;
  logic              pend = 1'b0, busy = 1'b0, tog = 1'b0, oe_q = 1'b1;
  int                cnt = 0, step = 0;
  fepe_op_t          op = OP_PROG;

  function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // status or array data while selected, inverse of last value otherwise
  assign dq_in = (!ce_n && !oe_n) ?
    (busy ? {(op == OP_PROG) ? ~pd[7] : 1'b0, tog, 6'h00} : rd(addr)) :
    ~last;
  assign rdy_busy = !busy;

  // capture writes by either strobe, decode commands, run the algorithms
  always @(posedge clk)
  begin
    oe_q <= oe_n;
    if (!ce_n && !oe_n)
      last <= dq_in;
    if (!ce_n && !oe_n && oe_q && busy)
      tog <= ~tog;
    if (!ce_n && !we_n)
    begin
      wa   <= addr;
      wd   <= dq_out;
      pend <= 1'b1;
    end
    else if (pend)
    begin
      pend <= 1'b0;
      if (!busy)
        case (step)
          0, 4: step <= (wd == UNLOCK_D1) ? step + 1 : 0;
          1, 5: step <= (wd == UNLOCK_D2) ? step + 1 : 0;
          2: step <= (wd == CMD_PROG) ? 3 : (wd == CMD_ERASE) ? 4 : 0;
          3:
          begin
            pa   <= wa;
            pd   <= wd;
            op   <= OP_PROG;
            busy <= 1'b1;
            cnt  <= PROG_CYC;
            step <= 0;
          end
          default:
          begin
            step <= 0;
            if (wd == CMD_CHIP || wd == CMD_SECT)
            begin
              pa   <= wa;
              op   <= (wd == CMD_CHIP) ? OP_CHIP : OP_SECT;
              busy <= 1'b1;
              cnt  <= ERASE_CYC;
            end
          end
        endcase
    end
    if (busy && !hang)
    begin
      if (cnt == 0)
      begin
        busy <= 1'b0;
        if (op == OP_PROG)
          mem[pa] = pd;
        else if (op == OP_CHIP)
          mem.delete();
        else
          foreach (mem[k])
            if (k[SECT_HI_BIT:SECT_LO_BIT] == pa[SECT_HI_BIT:SECT_LO_BIT])
              mem[k] = 8'hFF;
      end
      else
        cnt <= cnt - 1;
    end
  end
endmodule

// File: tb/fepe_host_assertions.sv
/*
  checker for the flash program/erase host: handshake, write strobe and
  read strobe relations seen at the top module pins.
  assumes one clock domain, sys_clk, and active low nrst.
*/
module fepe_host_assertions
(
  input wire logic                         sys_clk,
  input wire logic                         nrst,
  input wire logic                         req_valid,
  input wire logic                         req_ready,
  input wire logic                         rsp_valid,
  input wire logic                         rsp_timeout,
  input wire logic [fepe_pkg::ADDR_W-1:0] flash_addr,
  input wire logic [fepe_pkg::DATA_W-1:0] flash_dq_out,
  input wire logic                         flash_dq_oe,
  input wire logic                         flash_ce_n,
  input wire logic                         flash_we_n,
  input wire logic                         flash_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // combined write strobe, low only while a write pulse is on the pins
  wire wr_n = flash_ce_n | flash_we_n;

  a_take_drops_ready: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready stayed high after a taken request");
  a_rsp_one_cycle: assert property (rsp_valid |=> !rsp_valid)
    else $error("response pulse longer than one cycle");
  a_rsp_then_ready: assert property (rsp_valid |-> ##[1:3] req_ready)
    else $error("ready did not return after a response");
  a_no_rw_overlap: assert property (!(!flash_we_n && !flash_oe_n))
    else $error("write and output enable low together");
  a_read_released: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n)
    else $error("read cycle with data driven or chip deselected");
  a_wr_pulse_one: assert property ($fell(wr_n) |=> wr_n)
    else $error("write pulse not one cycle wide");
  a_wr_data_hold: assert property ($fell(wr_n) |=> $stable(flash_addr) && $stable(flash_dq_out) && flash_dq_oe)
    else $error("address or data moved during a write pulse");
  a_idle_no_write: assert property (req_ready |-> flash_we_n && wr_n)
    else $error("write strobe active while idle");
  a_timeout_resp: assert property ($rose(rsp_timeout) |-> rsp_valid)
    else $error("timeout flag rose without a response");

  c_resp_ok: cover property (rsp_valid && !rsp_timeout);
  c_resp_timeout: cover property (rsp_valid && rsp_timeout);
  c_ce_write: cover property ($fell(flash_ce_n) && !flash_we_n);
endmodule

bind fepe_host fepe_host_assertions u_fepe_host_assertions
(
  .sys_clk, .nrst, .req_valid, .req_ready, .rsp_valid, .rsp_timeout,
  .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n,
  .flash_oe_n
);

// File: tb/fepe_host_tb.sv
/*
  self-checking bench for the flash program/erase host.
  assumes the flash model on the far side and a 20 MHz clock.
*/
module fepe_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fepe_pkg::*;

  localparam logic [ADDR_W-1:0] ADR_A = 20'h01234;
  localparam logic [ADDR_W-1:0] ADR_B = 20'h23456;

  logic              sys_clk, nrst, req_valid, req_method, req_use_ce;
  fepe_op_t          req_op;
  logic [ADDR_W-1:0] req_addr, flash_addr;
  logic [DATA_W-1:0] req_data, rsp_data, flash_dq_in, flash_dq_out;
  logic              req_ready, rsp_valid, rsp_timeout, flash_dq_oe;
  logic              flash_ce_n, flash_we_n, flash_oe_n;
  logic              ready_busy_output, hang;
  int                mismatches = 0;
  int                compares = 0;

  fepe_host #(.POLL_LIMIT(64)) u_fepe_host
  (
    .sys_clk, .nrst, .req_valid, .req_op, .req_addr, .req_data,
    .req_method, .req_use_ce, .req_ready, .rsp_valid, .rsp_data,
    .rsp_timeout, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe,
    .flash_ce_n, .flash_we_n, .flash_oe_n, .ready_busy_output
  );

  fepe_flash_model u_fepe_flash_model
  (
    .clk(sys_clk), .addr(flash_addr), .dq_out(flash_dq_out),
    .ce_n(flash_ce_n), .we_n(flash_we_n), .oe_n(flash_oe_n), .hang,
    .dq_in(flash_dq_in), .rdy_busy(ready_busy_output)
  );

  // free running clock
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic summarize;
    if (mismatches == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic fail(input string msg);
    mismatches++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
      fail($sformatf("byte %h expected %h", got, exp));
  endtask

  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp)
      fail($sformatf("flag %b expected %b", got, exp));
  endtask

  // one request: held until taken, then wait for the response pulse
  task automatic run(input fepe_op_t op, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic m, ce);
    int n;
    n = 0;
    @(posedge sys_clk);
    req_valid  <= 1'b1;
    req_op     <= op;
    req_addr   <= a;
    req_data   <= d;
    req_method <= m;
    req_use_ce <= ce;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 100)
    begin
      fail("request not taken");
      summarize();
    end
    @(posedge sys_clk);
    req_valid <= 1'b0;
    n = 0;
    @(negedge sys_clk);
    while (rsp_valid !== 1'b1 && n < 5000)
    begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 5000)
    begin
      fail("no response");
      summarize();
    end
  endtask

  task automatic t_prog_poll;
    run(OP_PROG, ADR_A, 8'h5A, METHOD_POLL, 1'b0);
    chk8(rsp_data, 8'h5A);
    chk1(rsp_timeout, 1'b0);
    run(OP_READ, ADR_A, 8'h00, METHOD_POLL, 1'b0);
    chk8(rsp_data, 8'h5A);
    run(OP_READ, ADR_A + 20'h00001, 8'h00, METHOD_POLL, 1'b0);
    chk8(rsp_data, 8'hFF);
  endtask

  task automatic t_prog_toggle_ce;
    run(OP_PROG, ADR_B, 8'hC3, METHOD_TOGGLE, 1'b1);
    chk8(rsp_data, 8'hC3);
    run(OP_READ, ADR_B, 8'h00, METHOD_TOGGLE, 1'b0);
    chk8(rsp_data, 8'hC3);
  endtask

  task automatic t_sect_erase;
    run(OP_SECT, 20'h01000, 8'h00, METHOD_POLL, 1'b0);
    chk8(rsp_data, 8'hFF);
    run(OP_READ, ADR_A, 8'h00, METHOD_POLL, 1'b0);
    chk8(rsp_data, 8'hFF);
    run(OP_READ, ADR_B, 8'h00, METHOD_POLL, 1'b0);
    chk8(rsp_data, 8'hC3);
  endtask

  task automatic t_hang_timeout;
    int n;
    n = 0;
    hang <= 1'b1;
    run(OP_PROG, ADR_A, 8'h81, METHOD_POLL, 1'b0);
    chk1(rsp_timeout, 1'b1);
    hang <= 1'b0;
    while (ready_busy_output !== 1'b1 && n < 200)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk1(ready_busy_output, 1'b1);
    if (n >= 200)
      summarize();
    run(OP_READ, ADR_A, 8'h00, METHOD_POLL, 1'b0);
    chk8(rsp_data, 8'h81);
    chk1(rsp_timeout, 1'b0);
  endtask

  task automatic t_chip_erase;
    run(OP_CHIP, ADR_A, 8'h00, METHOD_TOGGLE, 1'b1);
    chk8(rsp_data, 8'hFF);
    run(OP_READ, ADR_A, 8'h00, METHOD_POLL, 1'b0);
    chk8(rsp_data, 8'hFF);
    run(OP_READ, ADR_B, 8'h00, METHOD_POLL, 1'b0);
    chk8(rsp_data, 8'hFF);
  endtask

  // main sequence: reset, then every scenario in turn
  initial
  begin
    nrst       = 1'b0;
    req_valid  = 1'b0;
    req_op     = OP_READ;
    req_addr   = '0;
    req_data   = '0;
    req_method = METHOD_POLL;
    req_use_ce = 1'b0;
    hang       = 1'b0;
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    t_prog_poll();
    t_prog_toggle_ce();
    t_sect_erase();
    t_hang_timeout();
    t_chip_erase();
    summarize();
  end
endmodule

// File: verilog/fepe_bus_cycle.sv
/*
  bus cycle engine: one read or one write cycle on the flash pins.
  assumes flash pins are synchronous to sys_clk; writes are strobed by
  we or, if use_ce is set, by ce while we is held low.
*/
module fepe_bus_cycle
  import fepe_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  fepe_bus_if.eng                bus,
  input  wire logic [DATA_W-1:0] dq_in,
  output logic      [ADDR_W-1:0] addr_q,
  output logic      [DATA_W-1:0] dq_out_q,
  output logic                   dq_oe_q,
  output logic                   ce_n_q,
  output logic                   we_n_q,
  output logic                   oe_n_q
);
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_PULSE = 2'b01,
    ST_HIGH  = 2'b11
  } fepe_cyc_t;

  fepe_cyc_t        st_q;
  logic [CNT_W-1:0] cnt_q;
  logic             wr_q;
  logic             cec_q;
  logic [DATA_W-1:0] rdata_q;
  logic             done_q;

  wire logic cnt_zero = (cnt_q == '0);
  // strobe phase length; a ce strobed write adds one we setup cycle
  wire logic [CNT_W-1:0] pulse_len =
    !bus.wr    ? CNT_W'(RD_ACCESS_CYC - 1) :
    bus.use_ce ? CNT_W'(WR_PULSE_CYC)
               : CNT_W'(WR_PULSE_CYC - 1);

  assign bus.done  = done_q;
  assign bus.rdata = rdata_q;

  // one bus cycle: strobe phase, then recovery high phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE; cnt_q <= '0; wr_q <= 1'b0; cec_q <= 1'b0;
      rdata_q <= '0; done_q <= 1'b0; addr_q <= '0; dq_out_q <= '0;
      dq_oe_q <= 1'b0; ce_n_q <= 1'b1; we_n_q <= 1'b1; oe_n_q <= 1'b1;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        ST_IDLE:
          if (bus.start)
          begin
            st_q     <= ST_PULSE;
            wr_q     <= bus.wr;
            cec_q    <= bus.use_ce;
            cnt_q    <= pulse_len;
            addr_q   <= bus.addr;
            dq_out_q <= bus.wdata;
            dq_oe_q  <= bus.wr;
            // [RULE13] ce strobed write
            ce_n_q   <= bus.wr && bus.use_ce ? 1'b1 : 1'b0;
            we_n_q   <= bus.wr && !bus.use_ce ? 1'b0 : !bus.wr;
            oe_n_q   <= bus.wr;
          end
        ST_PULSE:
          if (cnt_zero)
          begin
            // [RULE13] release the strobe
            st_q    <= ST_HIGH;
            cnt_q   <= CNT_W'(WR_HIGH_CYC - 1);
            rdata_q <= dq_in;
            ce_n_q  <= 1'b1;
            we_n_q  <= 1'b1;
            oe_n_q  <= 1'b1;
          end
          else
          begin
            cnt_q <= cnt_q - 1'b1;
            if (wr_q && cec_q)
              ce_n_q <= 1'b0; // ce pulse follows we setup
          end
        default:
          if (cnt_zero)
          begin
            st_q    <= ST_IDLE;
            dq_oe_q <= 1'b0;
            we_n_q  <= 1'b1;
            done_q  <= 1'b1;
          end
          else
            cnt_q <= cnt_q - 1'b1;
      endcase
    end
  end
endmodule

// File: verilog/fepe_bus_if.sv
/*
  interface between sequencer and bus cycle engine.
  assumes one clock domain; the engine runs one cycle per start pulse.
*/
interface fepe_bus_if;
  import fepe_pkg::*;
  logic              start;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              use_ce;
  logic              done;
  logic [DATA_W-1:0] rdata;
  modport seq (output start, wr, addr, wdata, use_ce, input done, rdata);
  modport eng (input start, wr, addr, wdata, use_ce, output done, rdata);
endinterface

// File: verilog/fepe_host.sv
/*
  host controller for embedded program and erase of a byte-wide nor flash.
  issues the command sequence, then polls status (data polling or toggle
  bit) until the embedded algorithm ends. assumes pins sync to sys_clk.
*/
// Functional notes
// [RULE1] program writes one byte per request
// [RULE2] no external verify read after program
// [RULE3] completion detected by poll or toggle
// [RULE4] poll bit inverted data while programming
// [RULE5] bit six toggles during embedded algorithm
// [RULE6] chip erase clears whole array
// [RULE7] no external verify after erase
// [RULE8] poll bit zero during erase, one after
// [RULE9] sector taken from address bits 12-18
// [RULE10] program takes about nine microseconds
// [RULE11] sector erase takes about 0.7 seconds
// [RULE12] busy pin asserts within 90 ns
// [RULE13] ce may strobe writes with we low
// [RULE14] read may follow ready at once
// [RULE15] toggle bit stops once algorithm ends
// [RULE16] poll until done before next command; code stops polling at POLL_LIMIT and reports a timeout
module fepe_host
  import fepe_pkg::*;
#(
  // status reads before giving up; about six cycles a read, so the
  // default spans erase times of tens of seconds
  parameter int unsigned POLL_LIMIT = 100000000
)
(
  input  wire logic                       sys_clk,
  input  wire logic                       nrst,
  input  wire logic                       req_valid,
  input  wire fepe_pkg::fepe_op_t         req_op,
  input  wire logic [fepe_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [fepe_pkg::DATA_W-1:0] req_data,
  input  wire logic                       req_method,
  input  wire logic                       req_use_ce,
  output logic                            req_ready,
  output logic                            rsp_valid,
  output logic      [fepe_pkg::DATA_W-1:0] rsp_data,
  output logic                            rsp_timeout,
  output logic      [fepe_pkg::ADDR_W-1:0] flash_addr,
  input  wire logic [fepe_pkg::DATA_W-1:0] flash_dq_in,
  output logic      [fepe_pkg::DATA_W-1:0] flash_dq_out,
  output logic                            flash_dq_oe,
  output logic                            flash_ce_n,
  output logic                            flash_we_n,
  output logic                            flash_oe_n,
  input  wire logic                       ready_busy_output
);
  import fepe_pkg::*;

  typedef enum logic [2:0]
  {
    S_IDLE   = 3'b000,
    S_CMD    = 3'b001,
    S_POLL   = 3'b011,
    S_CHECK  = 3'b010,
    S_DONE   = 3'b110
  } fepe_state_t;

  fepe_bus_if bus ();

  // reset release through two flops
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  fepe_state_t       st_q;
  fepe_op_t          op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] data_q;
  logic              method_q;
  logic              use_ce_q;
  logic [2:0]        step_q;
  logic              start_q;
  logic              wr_q;
  logic [ADDR_W-1:0] baddr_q;
  logic [DATA_W-1:0] bdata_q;
  logic [DATA_W-1:0] last_q;
  logic              have_last_q;
  logic [31:0]       polls_q;
  logic [CNT_W-1:0]  wait_q;

  // command byte for each step of a sequence
  function automatic logic [ADDR_W+DATA_W-1:0] cmd_word(
    input fepe_op_t op, input logic [2:0] step,
    input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [ADDR_W-1:0] sect;
    sect = '0;
    // [RULE9] sector address on bits 12-18
    sect[SECT_HI_BIT:SECT_LO_BIT] = a[SECT_HI_BIT:SECT_LO_BIT];
    case (step)
      3'd0: cmd_word = {UNLOCK_A1, UNLOCK_D1};
      3'd1: cmd_word = {UNLOCK_A2, UNLOCK_D2};
      3'd2: cmd_word = {UNLOCK_A1, (op == OP_PROG) ? CMD_PROG : CMD_ERASE};
      3'd3: cmd_word = (op == OP_PROG) ? {a, d} : {UNLOCK_A1, UNLOCK_D1};
      3'd4: cmd_word = {UNLOCK_A2, UNLOCK_D2};
      // [RULE6] chip erase command covers the whole array
      default: cmd_word = (op == OP_CHIP) ? {UNLOCK_A1, CMD_CHIP}
                                          : {sect, CMD_SECT};
    endcase
  endfunction

  // last write step index: program has 4 writes, erases have 6
  wire logic [2:0] last_step = (op_q == OP_PROG) ? 3'd3 : 3'd5;
  // word of the next step, loaded as the current write ends
  wire logic [ADDR_W+DATA_W-1:0] cw = cmd_word(op_q, step_q + 3'd1, addr_q,
                                                data_q);
  wire logic [DATA_W-1:0] rd = bus.rdata;
  // [RULE4] program done when poll bit matches data
  // [RULE8] erase done when poll bit reads one
  wire logic poll_target = (op_q == OP_PROG) ? data_q[POLL_BIT] : 1'b1;
  wire logic poll_done   = (rd[POLL_BIT] == poll_target);
  // [RULE5] compare bit six of two reads
  // [RULE15] stop when toggling ceases
  wire logic toggle_done = have_last_q &&
                           (rd[TOGGLE_BIT] == last_q[TOGGLE_BIT]);
  // [RULE3] either method ends polling
  wire logic algo_done = (method_q == METHOD_POLL) ? poll_done
                                                   : toggle_done;
  // [RULE10] [RULE11] limit must outlast program and erase times
  wire logic poll_out  = (polls_q == 32'(POLL_LIMIT));

  assign bus.start  = start_q;
  assign bus.wr     = wr_q;
  assign bus.addr   = baddr_q;
  assign bus.wdata  = bdata_q;
  assign bus.use_ce = use_ce_q;

  // request capture and sequencing
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= S_IDLE; op_q <= OP_PROG; addr_q <= '0; data_q <= '0;
      method_q <= METHOD_POLL; use_ce_q <= 1'b0; step_q <= '0;
      start_q <= 1'b0; wr_q <= 1'b0; baddr_q <= '0; bdata_q <= '0;
      last_q <= '0; have_last_q <= 1'b0; polls_q <= '0;
      req_ready <= 1'b0; rsp_valid <= 1'b0; rsp_data <= '0;
      rsp_timeout <= 1'b0;
      wait_q <= '0;
    end
    else
    begin
      start_q   <= 1'b0;
      rsp_valid <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          req_ready <= 1'b1;
          if (req_valid && req_ready)
          begin
            req_ready   <= 1'b0;
            op_q        <= req_op;
            addr_q      <= req_addr;
            data_q      <= req_data;
            method_q    <= req_method;
            use_ce_q    <= req_use_ce;
            step_q      <= '0;
            have_last_q <= 1'b0;
            polls_q     <= '0;
            rsp_timeout <= 1'b0;
            if (req_op == OP_READ)
            begin
              // [RULE14] read issued with no recovery wait
              st_q    <= S_CHECK;
              wr_q    <= 1'b0;
              baddr_q <= req_addr;
              start_q <= 1'b1;
            end
            else
            begin
              st_q <= S_CMD;
              wr_q <= 1'b1;
              // [RULE1] command words carry one byte
              {baddr_q, bdata_q} <= cmd_word(req_op, 3'd0, req_addr,
                                             req_data);
              start_q <= 1'b1;
            end
          end
        end
        S_CMD:
          if (bus.done)
          begin
            if (step_q == last_step)
            begin
              // [RULE2] [RULE7] straight to status, no verify pass
              st_q    <= S_POLL;
              wr_q    <= 1'b0;
              baddr_q <= addr_q;
              wait_q  <= CNT_W'(BUSY_DELAY_CYC);
            end
            else
            begin
              step_q             <= step_q + 3'd1;
              {baddr_q, bdata_q} <= cw;
              start_q            <= 1'b1;
            end
          end
        S_POLL:
          // [RULE12] first status read waits out the busy delay
          if (wait_q == '0)
          begin
            start_q <= 1'b1;
            st_q    <= S_CHECK;
          end
          else
            wait_q <= wait_q - 1'b1;
        S_CHECK:
          if (bus.done)
          begin
            if (op_q == OP_READ)
            begin
              rsp_data  <= rd;
              rsp_valid <= 1'b1;
              st_q      <= S_DONE;
            end
            // [RULE16] keep polling until the algorithm ends or the POLL_LIMIT count is reached
            else if (algo_done || poll_out)
            begin
              rsp_data    <= rd;
              rsp_valid   <= 1'b1;
              rsp_timeout <= poll_out && !algo_done;
              st_q        <= S_DONE;
            end
            else
            begin
              last_q      <= rd;
              have_last_q <= 1'b1;
              polls_q     <= polls_q + 32'd1;
              st_q        <= S_POLL;
            end
          end
        default:
          // [RULE16] next request once the flash shows ready, or at once after a timeout
          if (ready_busy_output || rsp_timeout)
            st_q <= S_IDLE;
      endcase
    end
  end

  // bus cycle engine drives the flash pins
  fepe_bus_cycle u_cycle
  (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .bus      (bus.eng),
    .dq_in    (flash_dq_in),
    .addr_q   (flash_addr),
    .dq_out_q (flash_dq_out),
    .dq_oe_q  (flash_dq_oe),
    .ce_n_q   (flash_ce_n),
    .we_n_q   (flash_we_n),
    .oe_n_q   (flash_oe_n)
  );
endmodule

// File: verilog/fepe_pkg.sv
/*
  constants for the flash program/erase host controller: command codes,
  bus widths, status bit positions and bus timing counts.
  assumes a 20 MHz system clock and an asynchronous byte-wide nor flash.
*/
package fepe_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned CLK_NS          = 50;
  localparam int unsigned ADDR_W          = 20;
  localparam int unsigned DATA_W          = 8;
  // status bit positions on the data bus
  localparam int unsigned POLL_BIT        = 7;
  localparam int unsigned TOGGLE_BIT      = 6;
  // sector select field on the address bus
  localparam int unsigned SECT_LO_BIT     = 12;
  localparam int unsigned SECT_HI_BIT     = 18;
  localparam int unsigned SECT_W          = SECT_HI_BIT - SECT_LO_BIT + 1;
  // bus phase timing (ns), converted to cycles, least times round up
  localparam int unsigned WR_PULSE_NS     = 35;
  localparam int unsigned WR_HIGH_NS      = 30;
  localparam int unsigned RD_ACCESS_NS    = 90;
  localparam int unsigned BUSY_DELAY_NS   = 90;
  localparam int unsigned WR_PULSE_CYC    =
    (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned WR_HIGH_CYC     =
    (WR_HIGH_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RD_ACCESS_CYC   =
    (RD_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned BUSY_DELAY_CYC  =
    (BUSY_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned CNT_W           = 4;
  // unlock addresses and command bytes
  localparam logic [ADDR_W-1:0] UNLOCK_A1 = 20'h00555;
  localparam logic [ADDR_W-1:0] UNLOCK_A2 = 20'h002AA;
  localparam logic [DATA_W-1:0] UNLOCK_D1 = 8'hAA;
  localparam logic [DATA_W-1:0] UNLOCK_D2 = 8'h55;
  localparam logic [DATA_W-1:0] CMD_PROG  = 8'hA0;
  localparam logic [DATA_W-1:0] CMD_ERASE = 8'h80;
  localparam logic [DATA_W-1:0] CMD_CHIP  = 8'h10;
  localparam logic [DATA_W-1:0] CMD_SECT  = 8'h30;
  // operation codes on the user port
  typedef enum logic [1:0]
  {
    OP_PROG  = 2'h0,
    OP_CHIP  = 2'h1,
    OP_SECT  = 2'h2,
    OP_READ  = 2'h3
  } fepe_op_t;
  // status polling method
  localparam logic METHOD_POLL   = 1'b0;
  localparam logic METHOD_TOGGLE = 1'b1;
endpackage
